/* File: sse_defs.vh */
/*
 * constants for the subtract and sleep execution unit.
 * assumes a core decoder that presents one decoded operation per instruction cycle.
 */
`ifndef SSE_DEFS_VH
`define SSE_DEFS_VH
// operation select codes
`define SSE_OP_NONE        3'h0
`define SSE_OP_LIT_SUB     3'h1
`define SSE_OP_FILE_SUB    3'h2
`define SSE_OP_FILE_SUBB   3'h3
`define SSE_OP_SLEEP       3'h4
// destination bit values
`define SSE_DEST_WORK      1'h0
`define SSE_DEST_FILE      1'h1
// reset values
`define SSE_WORK_RST       8'h00
`define SSE_WDT_RST        8'h00
`define SSE_PRESC_RST      8'h00
// status flag reset values: carry/dc/zero clear, power-down and time-out bits high
`define SSE_FLAG_RST       1'h0
`define SSE_STATUS_N_RST   1'h1
`endif

/* File: sse_exec.v */
/*
 * execution unit for literal/file subtracts, subtract with borrow, and enter-sleep.
 * assumes the core supplies the addressed file value in the same cycle as the op strobe
 * and writes back o_file_data when o_file_we pulses; watchdog ticks come from a divider.
 */
`default_nettype none
`include "sse_defs.vh"

// Notes on behaviour
// - literal subtract: 8-bit difference of literal minus working register
// - literal subtract writes working register, updates carry, digit carry, zero
// - sleep loads zero into watchdog counter and clears its prescaler
// - sleep clears power-down status bit, sets time-out status bit, leaves carry, digit carry and zero unchanged
// - after sleep the core halts with oscillator stopped; no operands
// - file subtract: file register minus working register, address 0 to 127
// - file subtract destination 0 goes to working, 1 back to file
// - borrow subtract: file minus working minus inverted carry, updates flags
// - borrow subtract destination 0 to working, 1 back to file
module sse_exec #(
  parameter WIDTH       = 8,
  parameter ADDR_WIDTH  = 7,
  parameter PRESC_WIDTH = 8
) (
  input  wire                  i_mclk,
  input  wire                  i_rst,
  input  wire                  i_op_valid,
  input  wire [2:0]            i_op_sel,
  input  wire [WIDTH-1:0]      i_literal,
  input  wire [ADDR_WIDTH-1:0] i_file_addr,
  input  wire                  i_dest,
  input  wire [WIDTH-1:0]      i_file_rdata,
  input  wire                  i_wdt_tick,
  input  wire                  i_wake,
  output reg  [WIDTH-1:0]      o_work,
  output reg                   o_carry_flag,
  output reg                   o_digit_carry_flag,
  output reg                   o_zero_flag,
  output reg                   o_power_down_status_n,
  output reg                   o_timeout_status_n,
  output reg                   o_file_we,
  output reg  [ADDR_WIDTH-1:0] o_file_waddr,
  output reg  [WIDTH-1:0]      o_file_data,
  output reg  [WIDTH-1:0]      o_watchdog_counter,
  output reg                   o_sleeping,
  output reg                   o_osc_run
);

  // ********************************
  // subtract core
  // ********************************
  // a - b - borrow with borrow outs from bits 3 and 7 (inverted to carry)
  function [WIDTH+1:0] sub_fn;
    input [WIDTH-1:0] a;
    input [WIDTH-1:0] b;
    input             bin;
    reg   [WIDTH:0]   full;
    reg   [4:0]       low;
    begin
      full   = {1'b0, a} - {1'b0, b} - {{WIDTH{1'b0}}, bin};
      low    = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
      sub_fn = {~full[WIDTH], ~low[4], full[WIDTH-1:0]};
    end
  endfunction

  reg [PRESC_WIDTH-1:0] presc;
  reg [WIDTH-1:0]       sub_a;
  reg                   sub_bin;
  reg [WIDTH+1:0]       sub_res;

  // ********************************
  // op decode
  // ********************************
  // ops arriving while halted are dropped; the core must wait for wake
  function op_is;
    input       valid;
    input       halted;
    input [2:0] sel;
    input [2:0] code;
    begin
      op_is = valid && !halted && (sel == code);
    end
  endfunction

  wire do_lit  = op_is(i_op_valid, o_sleeping, i_op_sel, `SSE_OP_LIT_SUB);
  wire do_file = op_is(i_op_valid, o_sleeping, i_op_sel, `SSE_OP_FILE_SUB);
  wire do_fsbb = op_is(i_op_valid, o_sleeping, i_op_sel, `SSE_OP_FILE_SUBB);
  wire do_slp  = op_is(i_op_valid, o_sleeping, i_op_sel, `SSE_OP_SLEEP);
  wire do_sub  = do_lit | do_file | do_fsbb;

  always @* begin
    sub_a   = do_lit ? i_literal : i_file_rdata;
    sub_bin = do_fsbb ? ~o_carry_flag : 1'b0;
    sub_res = sub_fn(sub_a, o_work, sub_bin);
  end

  // ********************************
  // state update
  // ********************************
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_work                <= `SSE_WORK_RST;
      o_carry_flag          <= `SSE_FLAG_RST;
      o_digit_carry_flag    <= `SSE_FLAG_RST;
      o_zero_flag           <= `SSE_FLAG_RST;
      o_power_down_status_n <= `SSE_STATUS_N_RST;
      o_timeout_status_n    <= `SSE_STATUS_N_RST;
      o_file_we             <= 1'b0;
      o_file_waddr          <= {ADDR_WIDTH{1'b0}};
      o_file_data           <= {WIDTH{1'b0}};
      o_watchdog_counter    <= `SSE_WDT_RST;
      presc                 <= `SSE_PRESC_RST;
      o_sleeping            <= 1'b0;
      o_osc_run             <= 1'b1;
    end else begin
      o_file_we <= 1'b0;
      if (do_sub) begin
        o_carry_flag       <= sub_res[WIDTH+1];
        o_digit_carry_flag <= sub_res[WIDTH];
        o_zero_flag        <= (sub_res[WIDTH-1:0] == {WIDTH{1'b0}});
        if (do_lit || i_dest == `SSE_DEST_WORK) begin
          o_work <= sub_res[WIDTH-1:0];
        end else begin
          o_file_we    <= 1'b1;
          o_file_waddr <= i_file_addr;
          o_file_data  <= sub_res[WIDTH-1:0];
        end
      end
      // watchdog keeps counting through sleep; only i_wake ends sleep, the counter never does
      if (do_slp) begin
        o_watchdog_counter    <= `SSE_WDT_RST;
        presc                 <= `SSE_PRESC_RST;
        o_power_down_status_n <= 1'b0;
        o_timeout_status_n    <= 1'b1;
        o_sleeping            <= 1'b1;
        o_osc_run             <= 1'b0;
      end else begin
        if (i_wdt_tick) begin
          presc <= presc + {{(PRESC_WIDTH-1){1'b0}}, 1'b1};
          if (presc == {PRESC_WIDTH{1'b1}}) begin
            o_watchdog_counter <= o_watchdog_counter + {{(WIDTH-1){1'b0}}, 1'b1};
          end
        end
        if (o_sleeping && i_wake) begin
          o_sleeping <= 1'b0;
          o_osc_run  <= 1'b1;
        end
      end
    end
  end

endmodule // sse_exec
`default_nettype wire

/* File: sse_exec_chk.sv */
/* checker for sse_exec subtract and sleep results.
   assumes default widths: 8-bit data, 7-bit file address. */
`default_nettype none
module sse_exec_chk(
  input wire logic i_mclk, i_rst, i_op_valid, i_dest, o_carry_flag, o_digit_carry_flag,
  input wire logic o_zero_flag, o_power_down_status_n, o_timeout_status_n, o_file_we,
  input wire logic o_sleeping, o_osc_run,
  input wire logic [2:0] i_op_sel,
  input wire logic [6:0] i_file_addr, o_file_waddr,
  input wire logic [7:0] i_literal, i_file_rdata, o_work, o_file_data, o_watchdog_counter);
  // ops are dropped while asleep, so gate on that
  wire logic tk = i_op_valid && !o_sleeping;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_lit_result: assert property (tk && i_op_sel == 3'h1 |=>
    o_work == $past(i_literal) - $past(o_work)) else $error("lit diff");
  a_lit_carry: assert property (tk && i_op_sel == 3'h1 |=>
    o_carry_flag == ($past(o_work) <= $past(i_literal))) else $error("lit carry");
  a_sleep_entry: assert property (tk && i_op_sel == 3'h4 |=>
    o_watchdog_counter == 8'h00 && !o_power_down_status_n && o_timeout_status_n
    && o_sleeping && !o_osc_run) else $error("sleep entry");
  a_file_to_file: assert property (tk && i_op_sel == 3'h2 && i_dest |=>
    o_file_we && o_file_data == $past(i_file_rdata) - $past(o_work)
    && o_file_waddr == $past(i_file_addr)) else $error("file write");
  a_file_to_work: assert property (tk && i_op_sel == 3'h2 && !i_dest |=>
    !o_file_we && o_work == $past(i_file_rdata) - $past(o_work)) else $error("file to work");
  a_borrow_sub: assert property (tk && i_op_sel == 3'h3 && !i_dest |=>
    o_work == $past(i_file_rdata) - $past(o_work) - {7'h00, !$past(o_carry_flag)})
    else $error("borrow sub");
  a_zero_flag: assert property (tk && i_op_sel != 3'h0 && i_op_sel < 3'h4 && !i_dest |=>
    o_zero_flag == (o_work == 8'h00)) else $error("zero flag");
  a_digit_carry: assert property (tk && i_op_sel == 3'h2 |=>
    o_digit_carry_flag == ($past(o_work[3:0]) <= $past(i_file_rdata[3:0]))) else $error("dc");
endmodule // sse_exec_chk
bind sse_exec sse_exec_chk u_chk(.*);
`default_nettype wire

/* File: tb_sse_exec.sv */
/* bench for sse_exec: subtracts, borrow chain, sleep and wake.
   assumes sse_exec_chk is compiled alongside. */
`default_nettype none
module tb_sse_exec;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 0, i_rst = 1, v = 0, d = 0, wk = 0, wt = 0;
  logic [6:0] a = 7'h00;
  logic [2:0] s = 0;
  logic [7:0] k = 0, f = 0;
  wire logic [7:0] w, fd, wd;
  wire logic [6:0] wa;
  wire logic c, dg, z, pdn, tos, we, sl, osc;
  int n_mismatch = 0, num_checks = 0;
  always #50 i_mclk = !i_mclk;
  sse_exec dut(.i_mclk(i_mclk), .i_rst(i_rst), .i_op_valid(v), .i_op_sel(s), .i_literal(k),
    .i_file_addr(a), .i_dest(d), .i_file_rdata(f), .i_wdt_tick(wt), .i_wake(wk),
    .o_work(w), .o_carry_flag(c), .o_digit_carry_flag(dg), .o_zero_flag(z),
    .o_power_down_status_n(pdn), .o_timeout_status_n(tos), .o_file_we(we),
    .o_file_waddr(wa), .o_file_data(fd), .o_watchdog_counter(wd), .o_sleeping(sl),
    .o_osc_run(osc));
  task chk(input string n, input logic [31:0] sn, e);
    num_checks++;
    if (sn !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", n, e, sn);
    end
  endtask
  task op(input logic [2:0] so, input logic [7:0] ko, fo, input logic dd);
    @(posedge i_mclk);
    #10 {v, s, k, f, d} = {1'b1, so, ko, fo, dd};
    @(posedge i_mclk);
    #10 v = 0;
  endtask
  task t_sub;
    op(3'h1, 8'h37, 8'h00, 1'b1);
    chk("work", w, 8'h37);
    op(3'h1, 8'h10, 8'h00, 1'b0);
    chk("flags", {w, c, dg, z}, 32'h0000_06C8);
    a = 7'h15;
    op(3'h2, 8'h00, 8'hD9, 1'b1);
    chk("fwr", {we, wa}, 32'h0000_0095);
    chk("fdat", {fd, c, dg, z}, 32'h0000_0007);
    op(3'h2, 8'h00, 8'h05, 1'b0);
    chk("work", {w, we, c, dg, z}, 32'h0000_02C0);
    op(3'h3, 8'h00, 8'h30, 1'b0);
    chk("bor", {w, c, dg, z}, 32'h0000_001C);
    a = 7'h7F;
    op(3'h3, 8'h00, 8'h03, 1'b1);
    chk("bor", {w, we, wa, fd, c, dg, z}, 32'h001F_F807);
  endtask
  task t_sleep;
    // 300 ticks leave the prescaler mid-count, so a missed clear shows up later
    wt = 1;
    repeat (300) @(posedge i_mclk);
    #10 chk("wdog", wd, 32'h0000_0001);
    op(3'h4, 8'h00, 8'h00, 1'b0);
    chk("slp", {pdn, tos, sl, osc, c, dg, z}, 32'h0000_0037);
    chk("wdog", wd, 32'h0000_0000);
    op(3'h1, 8'h55, 8'h00, 1'b0);
    chk("held", w, 32'h0000_0003);
    repeat (253) @(posedge i_mclk);
    #10 chk("presc", wd, 32'h0000_0000);
    wk = 1;
    @(posedge i_mclk);
    #10 chk("wake", {sl, osc}, 32'h0000_0001);
    chk("wrap", wd, 32'h0000_0001);
  endtask
  task wrap_up;
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_mclk);
    #10 i_rst = 0;
    chk("rst", {pdn, tos, sl, osc}, 8'h0D);
    t_sub;
    t_sleep;
    wrap_up;
  end
  initial begin
    #200000 n_mismatch++;
    wrap_up;
  end
endmodule // tb_sse_exec
`default_nettype wire
